/* logic/oled_seq_consts.svh */
// Constants shared by the power sequencer and the display driver model.
// Assumes a 200 MHz clock and inclusion by bare name.
`ifndef OLED_SEQ_CONSTS_SVH
`define OLED_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 5
`define SETTLE_TIME_MS 100
`define SETTLE_CYCLES ((`SETTLE_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define CONTRAST_RESET 8'h7F
`define START_LINE_RESET 6'h00
`define COLUMN_RESET 7'h00
`define MUX_RATIO_RESET 7'h3F
`define CMD_DISPLAY_OFF 8'hAE
`define CMD_DISPLAY_ON 8'hAF
`define CMD_SHOW_RAM 8'hA4
`define CMD_ENTIRE_ON 8'hA5
`define CMD_CONTRAST 8'h81
`define CMD_SEG_REMAP 8'hA1
`define CMD_COM_REVERSE 8'hC8
`define CMD_NORMAL_MAP 8'hA0
`define CMD_COM_NORMAL 8'hC0
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_CMD 4'h2
`define REG_STATE 4'h3
`define CTRL_UP_BIT 0
`define CTRL_DOWN_BIT 1
`define CTRL_RESET_BIT 2
`define CTRL_INIT_DONE_BIT 3
`define STATUS_BUSY_BIT 0
`define STATUS_LOGIC_BIT 1
`define STATUS_PANEL_BIT 2
`define STATUS_ON_BIT 3
`endif

/* logic/oled_seq_pkg.sv */
// Types shared by both ends of the power sequencing link.
// Assumes the constants header is compiled alongside.
package oled_seq_pkg;
  typedef enum {
    ST_OFF, ST_LOGIC_UP, ST_INIT, ST_PANEL_WAIT, ST_SEND_ON, ST_ON,
    ST_SEND_OFF, ST_DISCHARGE
  } seq_state_t;
endpackage

/* logic/oled_link_if.sv */
// Link between the host sequencer and the display driver end.
// Assumes one shared clock; the panel supply enable is a float-capable pin.
interface oled_link_if;
  logic logic_supply;
  logic panel_supply_o;
  logic panel_supply_oe_n;
  logic hw_reset_low;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic display_on;
  logic panel_supply;
  assign panel_supply = (!panel_supply_oe_n) ? panel_supply_o : 1'b0;
  modport host (output logic_supply, output panel_supply_o, output panel_supply_oe_n,
    output hw_reset_low, output cmd_valid, output cmd_byte, input display_on);
  modport device (input logic_supply, input panel_supply, input hw_reset_low,
    input cmd_valid, input cmd_byte, output display_on);
endinterface

/* logic/oled_driver_end.sv */
// Display driver end: keeps the command state that reset defines.
// Assumes commands arrive as one-cycle strobes on the link.
`include "oled_seq_consts.svh"
module oled_driver_end
  import oled_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  oled_link_if.device link,
  output logic o_display_on,
  output logic o_entire_on,
  output logic [7:0] o_contrast,
  output logic [6:0] o_mux_ratio,
  output logic o_seg_remap,
  output logic o_com_reverse,
  output logic [5:0] o_start_line,
  output logic [6:0] o_column,
  output logic [7:0] o_shift
);
  typedef struct packed {
    logic disp_on;
    logic entire_on;
    logic [7:0] contrast;
    logic [6:0] mux;
    logic seg_remap;
    logic com_rev;
    logic [5:0] start_line;
    logic [6:0] column;
    logic [7:0] shift;
    logic contrast_next;
  } drv_t;
  drv_t r;
  drv_t next_r;
  localparam drv_t RESET_VAL = '{disp_on: 1'b0, entire_on: 1'b0, contrast: `CONTRAST_RESET,
    mux: `MUX_RATIO_RESET, seg_remap: 1'b0, com_rev: 1'b0, start_line: `START_LINE_RESET,
    column: `COLUMN_RESET, shift: 8'h00, contrast_next: 1'b0};

  always_comb begin
    next_r = r;
    if (!link.hw_reset_low || !link.logic_supply) begin
      next_r = RESET_VAL;
    end else if (link.cmd_valid) begin
      next_r.shift = link.cmd_byte;
      if (r.contrast_next) begin
        next_r.contrast = link.cmd_byte;
        next_r.contrast_next = 1'b0;
      end else if (link.cmd_byte == `CMD_DISPLAY_ON) begin
        next_r.disp_on = 1'b1;
      end else if (link.cmd_byte == `CMD_DISPLAY_OFF) begin
        next_r.disp_on = 1'b0;
      end else if (link.cmd_byte == `CMD_SHOW_RAM) begin
        next_r.entire_on = 1'b0;
      end else if (link.cmd_byte == `CMD_ENTIRE_ON) begin
        next_r.entire_on = 1'b1;
      end else if (link.cmd_byte == `CMD_CONTRAST) begin
        next_r.contrast_next = 1'b1;
      end else if (link.cmd_byte == `CMD_SEG_REMAP) begin
        next_r.seg_remap = 1'b1;
      end else if (link.cmd_byte == `CMD_NORMAL_MAP) begin
        next_r.seg_remap = 1'b0;
      end else if (link.cmd_byte == `CMD_COM_REVERSE) begin
        next_r.com_rev = 1'b1;
      end else if (link.cmd_byte == `CMD_COM_NORMAL) begin
        next_r.com_rev = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign link.display_on = r.disp_on;
  assign o_display_on = r.disp_on;
  assign o_entire_on = r.entire_on;
  assign o_contrast = r.contrast;
  assign o_mux_ratio = r.mux;
  assign o_seg_remap = r.seg_remap;
  assign o_com_reverse = r.com_rev;
  assign o_start_line = r.start_line;
  assign o_column = r.column;
  assign o_shift = r.shift;
endmodule

/* logic/oled_host_seq.sv */
// Host power sequencer: orders logic and panel supplies around display commands.
// Assumes software uses the plain register port; init commands go through the command register.
//
// The register offsets and strobed register access were left to the implementer.
`include "oled_seq_consts.svh"
// What this block does
// - Logic supply, display off, init, then panel
// - Wait settle time after panel enable
// - Display on only after settle wait
// - Power down: display off, then panel off
// - Wait discharge time before logic off
// - Logic supply never drops before panel
// - Panel enable floats while panel off
// - Reset held low gives display off
// - Reset selects full multiplex mode
// - Reset selects normal segment/common mapping
// - Reset clears serial shift register
// - Reset sets start line zero
// - Reset sets column counter zero
// - Reset selects normal common scan
// - Reset loads contrast default
// - Reset shows RAM contents normally
// - Reset and reinitialize after noise corruption
module oled_host_seq
  import oled_seq_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_busy,
  oled_link_if.host link
);
  typedef struct packed {
    seq_state_t st;
    logic [24:0] cnt;
    logic logic_en;
    logic panel_en;
    logic rst_low;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic busy;
    logic init_done;
    logic [7:0] rdata;
  } host_t;
  host_t r;
  host_t next_r;
  logic cmd_wr;
  logic up_req;
  logic down_req;
  logic reset_req;
  logic done_req;
  localparam host_t RESET_VAL = '{
    st: ST_OFF,
    cnt: 25'h0000000,
    logic_en: 1'b0,
    panel_en: 1'b0,
    rst_low: 1'b0,
    cmd_valid: 1'b0,
    cmd_byte: 8'h00,
    busy: 1'b0,
    init_done: 1'b0,
    rdata: 8'h00
  };

  // Decodes the register port once; the state then decides which request counts.
  always_comb begin
    cmd_wr = 1'b0;
    up_req = 1'b0;
    down_req = 1'b0;
    reset_req = 1'b0;
    done_req = 1'b0;
    if (i_wr && i_addr == `REG_CMD) begin
      cmd_wr = 1'b1;
    end else if (i_wr && i_addr == `REG_CTRL) begin
      up_req = i_wdata[`CTRL_UP_BIT];
      down_req = i_wdata[`CTRL_DOWN_BIT];
      reset_req = i_wdata[`CTRL_RESET_BIT];
      done_req = i_wdata[`CTRL_INIT_DONE_BIT];
    end
  end

  // Command pulses and read data last one cycle unless set again.
  always_comb begin
    next_r = r;
    next_r.cmd_valid = 1'b0;
    next_r.rdata = 8'h00;
    if (i_rd) begin
      if (i_addr == `REG_STATUS) begin
        next_r.rdata = {4'h0, link.display_on, r.panel_en, r.logic_en, r.busy};
      end else if (i_addr == `REG_STATE) begin
        next_r.rdata = 8'(r.st);
      end else if (i_addr == `REG_CTRL) begin
        next_r.rdata = 8'(r.init_done) << `CTRL_INIT_DONE_BIT;
      end else begin
        next_r.rdata = 8'h00;
      end
    end
    case (r.st)
      ST_OFF: begin
        // Requests other than power-up are ignored while the block is off.
        next_r.busy = 1'b0;
        if (up_req) begin
          next_r.logic_en = 1'b1;
          next_r.rst_low = 1'b0;
          next_r.init_done = 1'b0;
          next_r.busy = 1'b1;
          next_r.st = ST_LOGIC_UP;
        end
      end
      ST_LOGIC_UP: begin
        // Reset rises one cycle after the logic supply, together with the first display-off command.
        next_r.rst_low = 1'b1;
        next_r.cmd_valid = 1'b1;
        next_r.cmd_byte = `CMD_DISPLAY_OFF;
        next_r.st = ST_INIT;
      end
      ST_INIT: begin
        // Software sends its initialization and clear-screen commands here.
        if (cmd_wr) begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd_byte = i_wdata;
        end else if (done_req) begin
          next_r.panel_en = 1'b1;
          next_r.cnt = '0;
          next_r.st = ST_PANEL_WAIT;
        end
      end
      ST_PANEL_WAIT: begin
        // The display stays dark until the panel supply has settled.
        next_r.cnt = r.cnt + 25'd1;
        if (r.cnt >= 25'(SETTLE_CYCLES - 1)) begin
          next_r.st = ST_SEND_ON;
        end
      end
      ST_SEND_ON: begin
        // Busy drops with the display-on pulse, so software may act the cycle after.
        next_r.cmd_valid = 1'b1;
        next_r.cmd_byte = `CMD_DISPLAY_ON;
        next_r.init_done = 1'b1;
        next_r.busy = 1'b0;
        next_r.st = ST_ON;
      end
      ST_ON: begin
        if (cmd_wr) begin
          next_r.cmd_valid = 1'b1;
          next_r.cmd_byte = i_wdata;
        end else if (reset_req) begin
          // The driver is dark while reset is low, so the panel may fall at once.
          next_r.rst_low = 1'b0;
          next_r.panel_en = 1'b0;
          next_r.cnt = '0;
          next_r.busy = 1'b1;
          next_r.st = ST_DISCHARGE;
        end else if (down_req) begin
          next_r.busy = 1'b1;
          next_r.st = ST_SEND_OFF;
        end
      end
      ST_SEND_OFF: begin
        // The panel stays on for this cycle so that display-off reaches the driver first.
        next_r.cmd_valid = 1'b1;
        next_r.cmd_byte = `CMD_DISPLAY_OFF;
        next_r.cnt = '0;
        next_r.st = ST_DISCHARGE;
      end
      ST_DISCHARGE: begin
        if (r.panel_en) begin
          next_r.panel_en = 1'b0;
          next_r.cnt = '0;
        end else begin
          next_r.cnt = r.cnt + 25'd1;
          // Logic is only dropped once the panel is known to be off.
          if (r.cnt >= 25'(SETTLE_CYCLES - 1)) begin
            next_r.logic_en = 1'b0;
            next_r.init_done = 1'b0;
            next_r.st = ST_OFF;
          end
        end
      end
      default: begin
        next_r.st = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  // Every output and link signal comes straight from the state flip-flops.
  assign o_rdata = r.rdata;
  assign o_busy = r.busy;
  assign link.logic_supply = r.logic_en;
  assign link.panel_supply_o = r.panel_en;
  assign link.panel_supply_oe_n = ~r.panel_en;
  assign link.hw_reset_low = r.rst_low;
  assign link.cmd_valid = r.cmd_valid;
  assign link.cmd_byte = r.cmd_byte;
endmodule

/* verification/oled_seq_chk.sv */
// Assertions on the link between the sequencer and the driver end.
// Assumes one clock; the bench instantiates it beside the link.
`include "oled_seq_consts.svh"
module oled_seq_chk #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic logic_supply,
  input wire logic panel_supply_o,
  input wire logic panel_supply_oe_n,
  input wire logic panel_supply,
  input wire logic hw_reset_low,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic display_on
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned on_cnt;
  int unsigned off_cnt;
  logic dark;
  wire logic off_cmd = cmd_valid && cmd_byte == `CMD_DISPLAY_OFF;
  wire logic on_cmd = cmd_valid && cmd_byte == `CMD_DISPLAY_ON;
  // Counts cycles in each panel state and remembers the last display order.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      on_cnt <= 0;
      off_cnt <= 0;
      dark <= 1'b0;
    end else begin
      on_cnt <= panel_supply ? on_cnt + 1 : 0;
      off_cnt <= panel_supply ? 0 : off_cnt + 1;
      dark <= off_cmd || (dark && !on_cmd);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_panel_needs_logic: assert property (panel_supply |-> logic_supply)
    else $error("panel on without logic");
  chk_panel_after_init: assert property ($rose(panel_supply) |-> dark && hw_reset_low)
    else $error("panel on before display off");
  chk_settle_before_on: assert property (on_cmd |-> on_cnt >= SETTLE_CYCLES)
    else $error("display on too early");
  chk_on_needs_panel: assert property (on_cmd |-> panel_supply && hw_reset_low)
    else $error("display on without panel");
  chk_down_dark_first: assert property ($fell(panel_supply) |-> !hw_reset_low || dark)
    else $error("panel off while display on");
  chk_discharge_wait: assert property ($fell(logic_supply) |-> off_cnt >= SETTLE_CYCLES)
    else $error("logic off too early");
  chk_never_drive_low: assert property (!panel_supply_oe_n |-> panel_supply_o)
    else $error("panel enable driven low");
  chk_reset_dark: assert property (!hw_reset_low || !logic_supply |=> !display_on)
    else $error("display on in reset");
  cover property ($rose(panel_supply));
  cover property (on_cmd);
  cover property ($fell(logic_supply));
  cover property ($fell(hw_reset_low) && logic_supply);
endmodule

/* verification/testbench.sv */
// Bench joining the sequencer and the driver end, with the link checker.
// Assumes the design files and the checker are compiled first.
`include "oled_seq_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SETTLE = 20;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata, o_contrast, o_shift, con;
  logic [6:0] o_mux_ratio, o_column;
  logic [5:0] o_start_line;
  logic o_busy, o_display_on, o_entire_on, o_seg_remap, o_com_reverse, remap;
  int err_total = 0;
  int num_checks = 0;
  oled_link_if oled_link_if_inst();
  oled_host_seq #(.SETTLE_CYCLES(SETTLE)) oled_host_seq_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy),
    .link(oled_link_if_inst));
  oled_driver_end oled_driver_end_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(oled_link_if_inst),
    .o_display_on(o_display_on), .o_entire_on(o_entire_on), .o_contrast(o_contrast), .o_mux_ratio(o_mux_ratio),
    .o_seg_remap(o_seg_remap), .o_com_reverse(o_com_reverse), .o_start_line(o_start_line),
    .o_column(o_column), .o_shift(o_shift));
  oled_seq_chk #(.SETTLE_CYCLES(SETTLE)) oled_seq_chk_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .logic_supply(oled_link_if_inst.logic_supply), .panel_supply_o(oled_link_if_inst.panel_supply_o),
    .panel_supply_oe_n(oled_link_if_inst.panel_supply_oe_n), .panel_supply(oled_link_if_inst.panel_supply),
    .hw_reset_low(oled_link_if_inst.hw_reset_low), .cmd_valid(oled_link_if_inst.cmd_valid),
    .cmd_byte(oled_link_if_inst.cmd_byte), .display_on(oled_link_if_inst.display_on));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  function automatic logic [7:0] st(input bit on);
    return on ? 8'((1 << `STATUS_ON_BIT) | (1 << `STATUS_PANEL_BIT) | (1 << `STATUS_LOGIC_BIT)) : 8'h00;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge i_clk);
    #1;
    for (int n = 0; n < 200 && o_busy !== 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    cmp(8'(o_busy), 8'h00);
  endtask
  task automatic check_defaults();
    cmp(8'(o_display_on), 8'h00);
    cmp(8'(o_mux_ratio), 8'(`MUX_RATIO_RESET));
    cmp(8'(o_seg_remap), 8'h00);
    cmp(o_shift, 8'h00);
    cmp(8'(o_start_line), 8'(`START_LINE_RESET));
    cmp(8'(o_column), 8'(`COLUMN_RESET));
    cmp(8'(o_com_reverse), 8'h00);
    cmp(o_contrast, `CONTRAST_RESET);
    cmp(8'(o_entire_on), 8'h00);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] d;
    void'($urandom(89));
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    check_defaults();
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      con = 8'($urandom);
      remap = 1'($urandom);
      wr(`REG_CTRL, 8'h01);
      repeat (3) @(posedge i_clk);
      wr(`REG_CMD, `CMD_CONTRAST);
      wr(`REG_CMD, con);
      wr(`REG_CMD, remap ? `CMD_SEG_REMAP : `CMD_NORMAL_MAP);
      wr(`REG_CMD, remap ? `CMD_ENTIRE_ON : `CMD_SHOW_RAM);
      wr(`REG_CMD, remap ? `CMD_COM_REVERSE : `CMD_COM_NORMAL);
      wr(`REG_CTRL, 8'h08);
      #1;
      cmp(8'(o_busy), 8'h01);
      wait_idle();
      rd(`REG_STATUS, d);
      cmp(d, st(1'b1));
      cmp(o_shift, `CMD_DISPLAY_ON);
      rd(`REG_CTRL, d);
      cmp(d, 8'(1 << `CTRL_INIT_DONE_BIT));
      rd(`REG_STATE, d);
      cmp(d, 8'(oled_seq_pkg::ST_ON));
      cmp(o_contrast, con);
      cmp(8'(o_seg_remap), 8'(remap));
      cmp(8'(o_com_reverse), 8'(remap));
      cmp(8'(o_entire_on), 8'(remap));
      wr(`REG_CTRL, 8'h01);
      wr(4'h9, 8'($urandom));
      rd(`REG_STATUS, d);
      cmp(d, st(1'b1));
      wr(`REG_CTRL, r[0] ? 8'h04 : 8'h02);
      wait_idle();
      rd(`REG_STATUS, d);
      cmp(d, st(1'b0));
      rd(`REG_CTRL, d);
      cmp(d, 8'h00);
      check_defaults();
      $display("test round %0d done", r);
    end
    wr(`REG_CTRL, 8'h01);
    wr(`REG_CMD, `CMD_CONTRAST);
    wr(`REG_CMD, 8'($urandom));
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    check_defaults();
    rd(`REG_STATUS, d);
    cmp(d, st(1'b0));
    rd(`REG_STATE, d);
    cmp(d, 8'(oled_seq_pkg::ST_OFF));
    $display("test mid-run reset done");
    end_sim();
  end
  // Four rounds take well under a thousand cycles; the limit allows four thousand.
  initial begin
    #20000;
    err_total++;
    $display("MISMATCH at %0t: watchdog", $time);
    end_sim();
  end
endmodule
